// ===== hw/amf_match_store.sv
// Matching-field store and compare for one rule entry per port
`timescale 1ns/1ps
`include "amf_defs.svh"
module amf_match_store #(
	parameter int NUM_PORTS = 5,
	parameter int NUM_BYTES = 9
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire amf_pkg::amf_reg_req_t REG_REQ,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic FRM_VALID,
	input wire amf_pkg::amf_frame_t FRM_INFO,
	output logic MATCH_VALID,
	output logic MATCH_HIT
);
	import amf_pkg::*;

	logic [7:0] select_r;
	logic [7:0] offset_r;
	logic [7:0] store_r [NUM_PORTS][NUM_BYTES];
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic sel_ok;
	logic ofs_ok;
	logic win_ok;
	logic [2:0] sel_port_idx;
	logic [3:0] sel_ofs_idx;
	logic [7:0] win_byte;
	logic [7:0] win_nxt;
	logic s1_valid_r;
	amf_frame_t s1_frame_r;
	logic [7:0] s1_entry_r [NUM_BYTES];
	logic s1_port_ok_r;
	logic s1_port_ok;
	logic [2:0] frm_port_idx;
	logic match_valid_r;
	logic match_hit_r;
	logic hit_nxt;

	// Port number one to five maps onto table rows zero to four
	function automatic logic port_in_range(input logic [3:0] p);
		port_in_range = (p >= `AMF_PORT_FIRST) && (p <= `AMF_PORT_LAST);
	endfunction : port_in_range

	function automatic logic [2:0] port_index(input logic [3:0] p);
		logic [3:0] d;
		d = p - `AMF_PORT_FIRST;
		port_index = d[2:0];
	endfunction : port_index

	// Bytes hold offsets 0x01..0x09 at rows zero to eight
	function automatic logic [3:0] byte_index(input logic [7:0] ofs);
		logic [7:0] d;
		d = ofs - `AMF_OFS_MODE;
		byte_index = d[3:0];
	endfunction : byte_index

	// Read-back view of a byte; meaning follows the layer mode
	function automatic logic [7:0] read_view(
		input logic [7:0] mode_byte,
		input logic [7:0] ofs,
		input logic [7:0] raw
	);
		amf_layer_mode_t m;
		m = amf_layer_mode_t'(mode_byte[`AMF_MODE_HI:`AMF_MODE_LO]);
		read_view = raw;
		if (ofs == `AMF_OFS_MODE)
		begin
			read_view = raw & `AMF_MODE_BYTE_MASK;
		end
		else if (m == AMF_MODE_L4)
		begin
			if (ofs == `AMF_OFS_B4)
			begin
				read_view = raw & `AMF_RANGE_MASK;
			end
		end
	endfunction : read_view

	// Write view; reserved bits of the mode byte stay zero
	function automatic logic [7:0] write_view(
		input logic [7:0] ofs,
		input logic [7:0] wdata
	);
		write_view = wdata;
		if (ofs == `AMF_OFS_MODE)
		begin
			write_view = wdata & `AMF_MODE_BYTE_MASK;
		end
	endfunction : write_view

	// Decode of the indirect window target
	always_comb
	begin
		sel_ok = (select_r[`AMF_SEL_TABLE_HI:`AMF_SEL_TABLE_LO]
			== `AMF_SEL_TABLE) && port_in_range(select_r[3:0]);
		ofs_ok = (offset_r >= `AMF_OFS_MODE) &&
			(offset_r <= `AMF_OFS_LAST);
		win_ok = sel_ok && ofs_ok;
		sel_port_idx = port_index(select_r[3:0]);
		sel_ofs_idx = byte_index(offset_r);
		win_byte = `AMF_BYTE_RESET;
		if (win_ok)
		begin
			win_byte = read_view(store_r[sel_port_idx][0], offset_r,
				store_r[sel_port_idx][sel_ofs_idx]);
		end
	end

	// Select and offset registers of the indirect path
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			select_r <= `AMF_BYTE_RESET;
			offset_r <= `AMF_BYTE_RESET;
		end
		else if (REG_REQ.wr)
		begin
			if (REG_REQ.addr == `AMF_REG_SELECT)
			begin
				select_r <= REG_REQ.wdata;
			end
			if (REG_REQ.addr == `AMF_REG_OFFSET)
			begin
				offset_r <= REG_REQ.wdata;
			end
		end
	end

	// Rule byte storage; every byte written from the data window, reset to zero
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				for (int b = 0; b < NUM_BYTES; b++)
				begin
					store_r[p][b] <= `AMF_BYTE_RESET;
				end
			end
		end
		else if (REG_REQ.wr && (REG_REQ.addr == `AMF_REG_DATA) && win_ok)
		begin
			store_r[sel_port_idx][sel_ofs_idx] <=
				write_view(offset_r, REG_REQ.wdata);
		end
	end

	// Register read path, answer one cycle after the strobe
	always_comb
	begin
		win_nxt = `AMF_BYTE_RESET;
		unique case (REG_REQ.addr)
			`AMF_REG_SELECT: win_nxt = select_r;
			`AMF_REG_OFFSET: win_nxt = offset_r;
			`AMF_REG_DATA: win_nxt = win_byte;
			default: win_nxt = `AMF_BYTE_RESET;
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			rdata_r <= `AMF_BYTE_RESET;
			rvalid_r <= 1'b0;
		end
		else
		begin
			// Read data is kept until the next read
			rvalid_r <= REG_REQ.rd;
			if (REG_REQ.rd)
			begin
				rdata_r <= win_nxt;
			end
		end
	end

	// Stage one: capture frame and the entry of its ingress port
	always_comb
	begin
		s1_port_ok = port_in_range(FRM_INFO.port);
		frm_port_idx = port_index(FRM_INFO.port);
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			s1_valid_r <= 1'b0;
			s1_port_ok_r <= 1'b0;
			s1_frame_r <= '0;
			for (int b = 0; b < NUM_BYTES; b++)
			begin
				s1_entry_r[b] <= `AMF_BYTE_RESET;
			end
		end
		else
		begin
			s1_valid_r <= FRM_VALID;
			if (FRM_VALID)
			begin
				s1_frame_r <= FRM_INFO;
				s1_port_ok_r <= s1_port_ok;
				for (int b = 0; b < NUM_BYTES; b++)
				begin
					if (s1_port_ok)
					begin
						s1_entry_r[b] <= store_r[frm_port_idx][b];
					end
					else
					begin
						// Unknown port has no row; avoid reading past the table
						s1_entry_r[b] <= `AMF_BYTE_RESET;
					end
				end
			end
		end
	end

	// Stage two: interpret bytes per layer mode and decide a hit
	always_comb
	begin
		logic [7:0] mode_byte;
		amf_layer_mode_t mode;
		amf_range_sel_t range_sel;
		logic [1:0] enb;
		logic use_src;
		logic sense;
		logic [39:0] rule_station;
		logic [39:0] frm_station;
		logic [15:0] rule_kind;
		logic [31:0] rule_net;
		logic [31:0] rule_wild;
		logic [31:0] frm_net;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [15:0] pnum;
		logic station_eq;
		logic kind_eq;
		logic same;
		logic active;
		mode_byte = s1_entry_r[0];
		mode = amf_layer_mode_t'(mode_byte[`AMF_MODE_HI:`AMF_MODE_LO]);
		enb = mode_byte[`AMF_ENB_HI:`AMF_ENB_LO];
		use_src = mode_byte[`AMF_SRC_BIT];
		sense = mode_byte[`AMF_SENSE_BIT];
		range_sel = amf_range_sel_t'(
			s1_entry_r[3][`AMF_RANGE_HI:`AMF_RANGE_LO]);
		// Layer 2 view, most significant byte first
		rule_station = {s1_entry_r[2], s1_entry_r[3], s1_entry_r[4],
			s1_entry_r[5], s1_entry_r[6]};
		rule_kind = {s1_entry_r[7], s1_entry_r[8]};
		frm_station = use_src ? s1_frame_r.src_station[39:0]
			: s1_frame_r.dst_station[39:0];
		// Layer 3 view
		rule_net = {s1_entry_r[1], s1_entry_r[2], s1_entry_r[3],
			s1_entry_r[4]};
		rule_wild = {s1_entry_r[5], s1_entry_r[6], s1_entry_r[7],
			s1_entry_r[8]};
		frm_net = use_src ? s1_frame_r.src_net
			: s1_frame_r.dst_net;
		// Layer 4 bounds
		upper = {s1_entry_r[1], `AMF_RANGE_HIGH_FILL};
		lower = {`AMF_RANGE_LOW_FILL, s1_entry_r[2]};
		pnum = s1_frame_r.l4_port;
		station_eq = (frm_station == rule_station);
		kind_eq = (s1_frame_r.frame_kind == rule_kind);
		same = 1'b0;
		active = 1'b1;
		unique case (mode)
			AMF_MODE_OFF:
			begin
				active = 1'b0;
			end
			AMF_MODE_L2:
			begin
				unique case (enb)
					2'h1: same = station_eq;
					2'h2: same = kind_eq;
					default: same = station_eq && kind_eq;
				endcase
			end
			AMF_MODE_L3:
			begin
				same = (((frm_net ^ rule_net) & rule_wild) == '0);
			end
			AMF_MODE_L4:
			begin
				unique case (range_sel)
					AMF_RANGE_OFF:
					begin
						active = 1'b0;
					end
					AMF_RANGE_EITHER:
					begin
						same = (pnum == upper) || (pnum == lower);
					end
					AMF_RANGE_INSIDE:
					begin
						same = (pnum >= lower) && (pnum <= upper);
					end
					AMF_RANGE_OUTSIDE:
					begin
						same = (pnum < lower) || (pnum > upper);
					end
				endcase
			end
		endcase
		hit_nxt = active && s1_port_ok_r && (sense ? same : !same);
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESETN)
		begin
			match_valid_r <= 1'b0;
			match_hit_r <= 1'b0;
		end
		else
		begin
			// Hit is kept between results
			match_valid_r <= s1_valid_r;
			if (s1_valid_r)
			begin
				match_hit_r <= hit_nxt;
			end
		end
	end

	// Every output comes straight from a flip-flop
	assign REG_RDATA = rdata_r;
	assign REG_RVALID = rvalid_r;
	assign MATCH_VALID = match_valid_r;
	assign MATCH_HIT = match_hit_r;

endmodule : amf_match_store

// ===== hw/amf_defs.svh
// Constants for the access-control matching-field store
// Notes on behaviour
// - Select bits 7:5 equal 010 target rules
// - Select bits 3:0 carry port one to five
// - Offset register picks byte; data window leaves it unchanged
// - Match sense set hits on equal, else differ
// - Station address bytes at 0x03-0x07, MSB first
// - Frame kind high 0x08, low 0x09
// - Network address at 0x02-0x05, MSB first
// - Network wildcard at 0x06-0x09, MSB first
// - Range upper high 0x02, lower low 0x03
// - Range select bits 2:1 at 0x04 choose compare
// - Layer mode: off, layer 2, 3, 4
// - Source select clear uses destination address
`ifndef AMF_DEFS_SVH
`define AMF_DEFS_SVH

`define AMF_REG_SELECT 8'h6e
`define AMF_REG_OFFSET 8'h6f
`define AMF_REG_DATA 8'ha0
`define AMF_SEL_TABLE 3'h2
`define AMF_SEL_TABLE_HI 7
`define AMF_SEL_TABLE_LO 5
`define AMF_PORT_FIRST 4'h1
`define AMF_PORT_LAST 4'h5
`define AMF_OFS_MODE 8'h01
`define AMF_OFS_LAST 8'h09
`define AMF_OFS_B2 8'h02
`define AMF_OFS_B3 8'h03
`define AMF_OFS_B4 8'h04
`define AMF_OFS_B5 8'h05
`define AMF_OFS_B6 8'h06
`define AMF_OFS_B7 8'h07
`define AMF_OFS_B8 8'h08
`define AMF_OFS_B9 8'h09
`define AMF_MODE_HI 5
`define AMF_MODE_LO 4
`define AMF_ENB_HI 3
`define AMF_ENB_LO 2
`define AMF_SRC_BIT 1
`define AMF_SENSE_BIT 0
`define AMF_MODE_BYTE_MASK 8'h3f
`define AMF_RANGE_HI 2
`define AMF_RANGE_LO 1
`define AMF_RANGE_MASK 8'h06
`define AMF_BYTE_RESET 8'h00
`define AMF_RANGE_LOW_FILL 8'h00
`define AMF_RANGE_HIGH_FILL 8'hff

`endif

// ===== hw/amf_pkg.sv
// Types for the access-control matching-field store
`include "amf_defs.svh"
package amf_pkg;

	typedef enum logic [1:0] {
		AMF_MODE_OFF,
		AMF_MODE_L2,
		AMF_MODE_L3,
		AMF_MODE_L4
	} amf_layer_mode_t;

	typedef enum logic [1:0] {
		AMF_RANGE_OFF,
		AMF_RANGE_EITHER,
		AMF_RANGE_INSIDE,
		AMF_RANGE_OUTSIDE
	} amf_range_sel_t;

	typedef struct packed {
		logic [3:0] port;
		logic [47:0] dst_station;
		logic [47:0] src_station;
		logic [15:0] frame_kind;
		logic [31:0] dst_net;
		logic [31:0] src_net;
		logic [15:0] l4_port;
	} amf_frame_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} amf_reg_req_t;

endpackage : amf_pkg

// ===== verification/amf_match_props.sv
// Port assertions for the matching-field store
`timescale 1ns/1ps
module amf_match_props
	import amf_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire amf_pkg::amf_reg_req_t REG_REQ,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic FRM_VALID,
	input wire amf_pkg::amf_frame_t FRM_INFO,
	input wire logic MATCH_VALID,
	input wire logic MATCH_HIT
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESETN);
	rd_answer_a: assert property (REG_REQ.rd |=> REG_RVALID)
		else $error("read answer missing");
	rvalid_cause_a: assert property (REG_RVALID |-> $past(REG_REQ.rd))
		else $error("read answer without read");
	rdata_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA))
		else $error("read data moved");
	unmapped_rd_a: assert property (REG_REQ.rd &&
		!(REG_REQ.addr inside {8'h6e, 8'h6f, 8'ha0}) |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	match_lat_a: assert property (FRM_VALID |-> ##2 MATCH_VALID)
		else $error("result marker late");
	match_cause_a: assert property (MATCH_VALID |-> $past(FRM_VALID, 2))
		else $error("result marker without frame");
	bad_port_a: assert property (FRM_VALID &&
		(FRM_INFO.port == 4'h0 || FRM_INFO.port > 4'h5) |-> ##2 !MATCH_HIT)
		else $error("hit on unknown port");
	hit_hold_a: assert property (!MATCH_VALID |-> $stable(MATCH_HIT))
		else $error("hit changed without result");
endmodule : amf_match_props

bind amf_match_store amf_match_props u_props (.CORE_CLK(CORE_CLK),
	.RESETN(RESETN), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .FRM_VALID(FRM_VALID), .FRM_INFO(FRM_INFO),
	.MATCH_VALID(MATCH_VALID), .MATCH_HIT(MATCH_HIT));

// ===== verification/amf_host_model.sv
// Host model that speaks the register window
`timescale 1ns/1ps
module amf_host_model
	import amf_pkg::*;
(
	input logic clk,
	output amf_pkg::amf_reg_req_t req,
	input logic [7:0] rdata,
	input logic rvalid
);
	initial req = '0;
	// Released address and data show the inverse of their last value
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		d = rvalid ? rdata : 8'hxx;
		req = '{1'b0, 1'b0, ~a, 8'hff};
	endtask : rd
endmodule : amf_host_model

// ===== verification/tb_amf_match_store.sv
// Testbench for the matching-field store
`timescale 1ns/1ps
module tb_amf_match_store;
	import amf_pkg::*;
	logic core_clk;
	logic resetn;
	amf_reg_req_t req;
	logic [7:0] rdata;
	logic rvalid;
	logic frm_valid;
	amf_frame_t frm;
	logic match_valid;
	logic match_hit;
	logic [7:0] v;
	int mismatches;
	int n_tests;
	amf_match_store dut (.CORE_CLK(core_clk), .RESETN(resetn),
		.REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.FRM_VALID(frm_valid), .FRM_INFO(frm),
		.MATCH_VALID(match_valid), .MATCH_HIT(match_hit));
	amf_host_model host (.clk(core_clk), .req(req), .rdata(rdata),
		.rvalid(rvalid));
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
		n_tests++;
		if (seen !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk
	task put(input logic [3:0] p, input logic [7:0] o, input logic [7:0] d);
		host.wr(8'h6e, {3'b010, 1'b0, p});
		host.wr(8'h6f, o);
		host.wr(8'ha0, d);
	endtask : put
	task get(input logic [3:0] p, input logic [7:0] o, input logic [7:0] e);
		host.wr(8'h6e, {3'b010, 1'b0, p});
		host.wr(8'h6f, o);
		host.rd(8'ha0, v);
		chk("entry byte", v, e);
	endtask : get
	task send(input logic [3:0] p, input logic [47:0] st,
		input logic [31:0] nt, input logic [15:0] l4, input logic e);
		@(negedge core_clk);
		frm = '{p, st, ~st, 16'h0000, nt, ~nt, l4};
		frm_valid = 1'b1;
		@(negedge core_clk);
		frm_valid = 1'b0;
		@(negedge core_clk);
		chk("result marker", {7'h00, match_valid}, 8'h01);
		chk("rule hit", {7'h00, match_hit}, {7'h00, e});
	endtask : send
	task results;
		$display("mismatches %0d comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (4000) @(posedge core_clk);
		mismatches++;
		results();
	end
	initial
	begin
		resetn = 1'b0;
		frm_valid = 1'b0;
		frm = '0;
		repeat (5) @(negedge core_clk);
		resetn = 1'b1;
		for (int o = 2; o < 10; o++)
			get(4'h3, o[7:0], 8'h00);
		host.rd(8'h6e, v);
		chk("select", v, 8'h43);
		host.rd(8'h55, v);
		chk("unmapped", v, 8'h00);
		for (int o = 2; o < 10; o++)
			put(4'h2, o[7:0], 8'h11 * o[7:0]);
		for (int o = 2; o < 10; o++)
			get(4'h2, o[7:0], 8'h11 * o[7:0]);
		get(4'h1, 8'h03, 8'h00);
		put(4'h6, 8'h03, 8'hff);
		get(4'h6, 8'h03, 8'h00);
		host.wr(8'h6e, 8'h82);
		host.wr(8'h6f, 8'h03);
		host.wr(8'ha0, 8'hff);
		get(4'h2, 8'h03, 8'h33);
		put(4'h1, 8'h01, 8'hff);
		get(4'h1, 8'h01, 8'h3f);
		put(4'h1, 8'h01, 8'h35);
		put(4'h1, 8'h04, 8'hff);
		get(4'h1, 8'h04, 8'h06);
		put(4'h1, 8'h01, 8'h15);
		for (int o = 3; o < 8; o++)
			put(4'h1, o[7:0], {2{o[3:0] - 4'h2}});
		send(4'h1, 48'h1122334455, 32'h0, 16'h0, 1'b1);
		send(4'h1, 48'h1122334456, 32'h0, 16'h0, 1'b0);
		send(4'h6, 48'h1122334455, 32'h0, 16'h0, 1'b0);
		put(4'h1, 8'h01, 8'h14);
		send(4'h1, 48'h1122334455, 32'h0, 16'h0, 1'b0);
		send(4'h1, 48'h1122334456, 32'h0, 16'h0, 1'b1);
		put(4'h1, 8'h01, 8'h17);
		send(4'h1, ~48'h1122334455, 32'h0, 16'h0, 1'b1);
		put(4'h1, 8'h01, 8'h19);
		send(4'h1, 48'h0, 32'h0, 16'h0, 1'b1);
		put(4'h1, 8'h01, 8'h1d);
		send(4'h1, 48'h0, 32'h0, 16'h0, 1'b0);
		put(4'h1, 8'h01, 8'h25);
		for (int o = 2; o < 10; o++)
			put(4'h1, o[7:0], o < 4 ? 8'hc1 - o[7:0] : (o < 6 ? 8'h01 :
				(o < 9 ? 8'hff : 8'h00)));
		send(4'h1, 48'h0, 32'hbfbe01ff, 16'h0, 1'b1);
		send(4'h1, 48'h0, 32'hbfbe02ff, 16'h0, 1'b0);
		put(4'h1, 8'h01, 8'h35);
		put(4'h1, 8'h02, 8'h10);
		put(4'h1, 8'h03, 8'h20);
		put(4'h1, 8'h04, 8'h04);
		send(4'h1, 48'h0, 32'h0, 16'h0500, 1'b1);
		send(4'h1, 48'h0, 32'h0, 16'h2000, 1'b0);
		put(4'h1, 8'h04, 8'h06);
		send(4'h1, 48'h0, 32'h0, 16'h2000, 1'b1);
		put(4'h1, 8'h04, 8'h02);
		send(4'h1, 48'h0, 32'h0, 16'h0020, 1'b1);
		put(4'h1, 8'h04, 8'h00);
		send(4'h1, 48'h0, 32'h0, 16'h0500, 1'b0);
		put(4'h1, 8'h01, 8'h05);
		send(4'h1, 48'h0, 32'h0, 16'h0500, 1'b0);
		@(negedge core_clk);
		resetn = 1'b0;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		host.rd(8'h6e, v);
		chk("select after reset", v, 8'h00);
		get(4'h1, 8'h02, 8'h00);
		results();
	end
endmodule : tb_amf_match_store
